// ===== hw/mau_defs.svh
/*
  Register offsets, field positions, reset values and pipeline counts of the multiply-add unit.
  Assumes inclusion by bare name from the design files; holds definitions only.
*/
`ifndef MAU_DEFS_SVH
`define MAU_DEFS_SVH

`define MAU_AXI_AW 8
`define MAU_OFF_CTRL 8'h00
`define MAU_OFF_COUNT 8'h04
`define MAU_OFF_RES_LO 8'h08
`define MAU_OFF_RES_HI 8'h0c
`define MAU_CTRL_RUN_BIT 0
`define MAU_CTRL_RST 32'h0000_0001
`define MAU_COUNT_RST 32'h0000_0000
`define MAU_OPT_LAT 3
`define MAU_RESP_OKAY 2'b00
`define MAU_RESP_SLVERR 2'b10

`endif

// ===== hw/mau_pkg.sv
/*
  Types shared by the multiply-add unit: operation modes, write channel states, write capture flags.
  Assumes compilation before every module that imports it.
*/
package mau_pkg;

  typedef enum logic [1:0] {
    MAU_OP_ADD = 2'b00,
    MAU_OP_SUB = 2'b01,
    MAU_OP_SEL = 2'b10
  } mau_op_t;

  typedef enum logic [1:0] {
    MAU_WR_IDLE = 2'b00,
    MAU_WR_RESP = 2'b01
  } mau_wr_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
  } mau_wcap_t;

endpackage

// ===== hw/mau_delay.sv
/*
  Enable-gated delay line of DEPTH registers; depth zero is a plain wire.
  Assumes a synchronous active-low reset and one clock.
*/
`timescale 1ns/100ps
module mau_delay #(
  parameter int W = 8,
  parameter int DEPTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic adv,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  if (DEPTH < 0 || W < 1) begin : g_bad
    $error("mau_delay: depth must be non-negative");
  end
  if (DEPTH == 0) begin : g_wire
    assign dout = din;
  end else begin : g_pipe
    logic [W-1:0] pipe [DEPTH];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        for (int i = 0; i < DEPTH; i++) begin
          pipe[i] <= '0;
        end
      end else if (adv) begin
        pipe[0] <= din;
        for (int i = 1; i < DEPTH; i++) begin
          pipe[i] <= pipe[i-1];
        end
      end
    end
    assign dout = pipe[DEPTH-1];
  end
endmodule

// ===== hw/mau_prec.sv
/*
  Requantises a signed fixed-point value to a narrower width and binary point.
  Truncates surplus fraction bits and wraps on overflow; assumes OUT_BP is at most IN_BP.
*/
`timescale 1ns/100ps
module mau_prec #(
  parameter int IN_W = 33,
  parameter int IN_BP = 0,
  parameter int OUT_W = 33,
  parameter int OUT_BP = 0
) (
  input wire logic signed [IN_W-1:0] din,
  output logic [OUT_W-1:0] dout
);
  localparam int XW = (IN_W > OUT_W) ? IN_W : OUT_W;
  localparam int SH = IN_BP - OUT_BP;
  if (SH < 0 || OUT_BP > OUT_W || OUT_W < 1) begin : g_bad
    $error("mau_prec: output binary point not servable");
  end
  wire logic signed [XW-1:0] ext = XW'(din);
  wire logic signed [XW-1:0] shifted = ext >>> SH;
  assign dout = shifted[OUT_W-1:0];
endmodule

// ===== hw/mau_top.sv
/*
  Multiply-add unit: result = a*b +/- c, delayed by a build-time latency, with an AXI4-Lite
  control and status port. Assumes operands, subtract and enable synchronous to aclk and
  one AXI4-Lite master with at most one write and one read under way.
*/
// What the document asks of this block and its feeding logic
// [RQ1] The result is the product of operands a and b, with operand c then added or subtracted.
// [RQ2] In the fixed-add build the unit always adds c and ignores the subtract input.
// [RQ3] In the fixed-subtract build the unit always subtracts c and ignores the subtract input.
// [RQ4] In the selectable build subtract high means subtract and low means add, sample by sample.
// [RQ5] The feeding logic gives all three operands one identical floating-point format.
// [RQ6] The feeding logic places c's binary point at the sum of the binary points of a and b.
// [RQ7] With the enable port built, work proceeds only while enable is high.
// [RQ8] The output lags the inputs that made it by the configured number of samples.
// [RQ9] Fixed-point latency is 0 or -1 (optimal pipeline), and only -1 when enable is built.
// [RQ10] Floating-point latency is 0 or positive, and only positive when enable is built. This variant rejects every floating-point build.
// [RQ11] Full precision sizes the result to hold the exact value.
// [RQ12] User precision gives a narrower width or fraction, signed or unsigned as configured.
// [RQ13] Floating-point results are always at full precision. This variant rejects every floating-point build.
// [RQ14] While enable is low all pipeline registers and the output hold.
`timescale 1ns/100ps
`include "mau_defs.svh"
module mau_top
  import mau_pkg::*;
#(
  parameter mau_op_t OP_MODE = MAU_OP_SEL,
  parameter bit IS_FLOAT = 1'b0,
  parameter bit HAS_EN = 1'b1,
  parameter int LATENCY = -1,
  parameter int A_W = 16,
  parameter int A_BP = 0,
  parameter int B_W = 16,
  parameter int B_BP = 0,
  parameter int C_W = 32,
  parameter bit FULL_PREC = 1'b1,
  parameter int OUT_W = 32,
  parameter int OUT_BP = 0,
  parameter bit OUT_SIGNED = 1'b1,
  localparam int P_W = A_W + B_W,
  localparam int F_W = ((P_W > C_W) ? P_W : C_W) + 1,
  localparam int F_BP = A_BP + B_BP,
  localparam bit USE_FULL = FULL_PREC || IS_FLOAT,
  localparam int RES_W = USE_FULL ? F_W : OUT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic signed [A_W-1:0] op_a,
  input wire logic signed [B_W-1:0] op_b,
  input wire logic signed [C_W-1:0] op_c,
  input wire logic subtract,
  input wire logic enable,
  output logic [RES_W-1:0] result,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`MAU_AXI_AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`MAU_AXI_AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  localparam int LAT_EFF = (LATENCY < 0) ? `MAU_OPT_LAT : LATENCY;
  localparam int RES_BP = USE_FULL ? F_BP : OUT_BP;

  // Build-time checks on the latency and width options.
  if (!IS_FLOAT && !(LATENCY == 0 || LATENCY == -1)) begin : g_lat_fix // [RQ9]
    $error("mau_top: fixed-point latency must be 0 or -1");
  end
  if (!IS_FLOAT && HAS_EN && LATENCY != -1) begin : g_lat_fix_en // [RQ9]
    $error("mau_top: fixed-point latency with enable must be -1");
  end
  if (IS_FLOAT && LATENCY < 0) begin : g_lat_flt // [RQ10]
    $error("mau_top: floating-point latency must be 0 or positive");
  end
  if (IS_FLOAT && HAS_EN && LATENCY < 1) begin : g_lat_flt_en // [RQ10]
    $error("mau_top: floating-point latency with enable must be positive");
  end
  // The floating-point arithmetic core is not part of this variant; any floating-point build is rejected.
  if (IS_FLOAT) begin : g_no_flt
    $error("mau_top: floating-point operands are not served by this datapath");
  end
  if (RES_W > 64 || A_W < 1 || B_W < 1 || C_W < 1) begin : g_bad_w
    $error("mau_top: operand or result width not servable");
  end

  // Control register state.
  logic run;
  logic [31:0] count;
  // Only the run bit of the control reset word is kept in a flip-flop.
  localparam logic [31:0] CTRL_RST = `MAU_CTRL_RST;

  // The enable port, when absent, is treated as always high.
  wire logic en_port = HAS_EN ? enable : 1'b1; // [RQ7]
  wire logic adv = run & en_port; // [RQ7] [RQ14]

  // Arithmetic in full precision; the extra bit keeps the sum exact.
  wire logic signed [P_W-1:0] prod = op_a * op_b; // [RQ1]
  wire logic signed [F_W-1:0] prod_x = F_W'(prod); // [RQ11]
  wire logic signed [F_W-1:0] c_x = F_W'(op_c); // [RQ6]
  wire logic sel_sub = (OP_MODE == MAU_OP_SEL) & subtract; // [RQ4]
  wire logic do_sub = (OP_MODE == MAU_OP_SUB) | sel_sub; // [RQ2] [RQ3]
  wire logic signed [F_W-1:0] sum_add = prod_x + c_x; // [RQ1]
  wire logic signed [F_W-1:0] sum_sub = prod_x - c_x; // [RQ1]
  wire logic signed [F_W-1:0] full = do_sub ? sum_sub : sum_add;
  logic [RES_W-1:0] res_comb;

  // Full precision passes through unchanged; user precision truncates and wraps.
  mau_prec #(
    .IN_W(F_W),
    .IN_BP(F_BP),
    .OUT_W(RES_W),
    .OUT_BP(RES_BP)
  ) u_prec ( // [RQ12] [RQ13]
    .din(full),
    .dout(res_comb)
  );

  // The pipeline is a delay after the arithmetic so that synthesis may retime it into the multiplier.
  mau_delay #(
    .W(RES_W),
    .DEPTH(LAT_EFF)
  ) u_dly ( // [RQ8] [RQ14]
    .aclk(aclk),
    .aresetn(aresetn),
    .adv(adv),
    .din(res_comb),
    .dout(result)
  );

  // Accepted sample counter, visible to software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= `MAU_COUNT_RST;
    end else if (adv) begin
      count <= count + 32'h0000_0001;
    end
  end

  // Result extended to 64 bits for the two read words.
  wire logic res_sign = OUT_SIGNED | USE_FULL;
  wire logic res_msb = res_sign & result[RES_W-1]; // [RQ12]
  wire logic [63:0] res_ext = {{(64 - RES_W){res_msb}}, result};

  // AXI4-Lite write side.
  mau_wr_t wst;
  mau_wcap_t cap;
  logic [`MAU_AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  wire logic aw_hs = awvalid & awready;
  wire logic w_hs = wvalid & wready;
  wire logic b_hs = bvalid & bready;
  wire logic wr_fire = (wst == MAU_WR_IDLE) & cap.aw_got & cap.w_got;
  wire logic wr_ctrl = wr_addr == `MAU_OFF_CTRL;
  wire logic wr_ro = (wr_addr == `MAU_OFF_COUNT) | (wr_addr == `MAU_OFF_RES_LO) |
    (wr_addr == `MAU_OFF_RES_HI);
  wire logic wr_hit = wr_ctrl | wr_ro;
  wire logic [1:0] next_bresp = wr_hit ? `MAU_RESP_OKAY : `MAU_RESP_SLVERR;
  wire logic ctrl_we = wr_fire & wr_ctrl & wr_strb[0];
  wire logic next_run = wr_data[`MAU_CTRL_RUN_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst <= MAU_WR_IDLE;
      cap <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `MAU_RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      case (wst)
        MAU_WR_IDLE: begin
          awready <= ~(cap.aw_got | aw_hs);
          wready <= ~(cap.w_got | w_hs);
          if (aw_hs) begin
            cap.aw_got <= 1'b1;
            wr_addr <= awaddr;
          end
          if (w_hs) begin
            cap.w_got <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
          end
          if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= next_bresp;
            wst <= MAU_WR_RESP;
          end
        end
        MAU_WR_RESP: begin
          if (b_hs) begin
            bvalid <= 1'b0;
            cap <= '0;
            awready <= 1'b1;
            wready <= 1'b1;
            wst <= MAU_WR_IDLE;
          end
        end
        default: begin
          wst <= MAU_WR_IDLE;
        end
      endcase
    end
  end

  // Control register; the run bit gates every pipeline advance.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= CTRL_RST[`MAU_CTRL_RUN_BIT];
    end else if (ctrl_we) begin
      run <= next_run;
    end
  end

  // AXI4-Lite read side; one read in flight.
  wire logic ar_hs = arvalid & arready;
  wire logic r_hs = rvalid & rready;
  wire logic rd_ctrl = araddr == `MAU_OFF_CTRL;
  wire logic rd_cnt = araddr == `MAU_OFF_COUNT;
  wire logic rd_lo = araddr == `MAU_OFF_RES_LO;
  wire logic rd_hi = araddr == `MAU_OFF_RES_HI;
  wire logic rd_hit = rd_ctrl | rd_cnt | rd_lo | rd_hi;
  wire logic [31:0] ctrl_word = {31'h0000_0000, run};
  wire logic [31:0] next_rdata = rd_ctrl ? ctrl_word :
    rd_cnt ? count :
    rd_lo ? res_ext[31:0] :
    rd_hi ? res_ext[63:32] : 32'h0000_0000;
  wire logic [1:0] next_rresp = rd_hit ? `MAU_RESP_OKAY : `MAU_RESP_SLVERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `MAU_RESP_OKAY;
    end else if (ar_hs) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end else if (r_hs) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Checks on the datapath and the register port.
  chk_sum_exact: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1] [RQ2] [RQ11]
    (OP_MODE == MAU_OP_ADD) |-> (full == F_W'(op_a) * F_W'(op_b) + F_W'(op_c)))
    else $error("Fixed add result differs from a*b+c.");

  chk_sub_fixed: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ3]
    (OP_MODE == MAU_OP_SUB) |-> (full == F_W'(op_a) * F_W'(op_b) - F_W'(op_c)))
    else $error("Fixed subtract result differs from a*b-c.");

  chk_sub_select: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ4]
    (OP_MODE == MAU_OP_SEL) |-> (full == (subtract ? F_W'(op_a) * F_W'(op_b) - F_W'(op_c) :
    F_W'(op_a) * F_W'(op_b) + F_W'(op_c))))
    else $error("Subtract input did not choose the operation.");

  chk_lat_opt: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8]
    (LAT_EFF == 3 && adv) ##1 adv ##1 adv |=> (result == $past(res_comb, 3)))
    else $error("Result did not appear three samples after its operands.");

  chk_lat_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8] [RQ9]
    (LAT_EFF == 0) |-> (result == res_comb))
    else $error("Zero-latency result is not combinational.");

  chk_hold_out: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ14] [RQ7]
    (HAS_EN && !enable) |=> $stable(result) && $stable(count))
    else $error("Pipeline moved while enable was low.");

  chk_run_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7]
    adv |=> (count == $past(count) + 32'h0000_0001))
    else $error("Sample counter missed an accepted sample.");

  chk_prec_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ12]
    (!USE_FULL && RES_BP == F_BP) |-> (res_comb == full[RES_W-1:0]))
    else $error("User precision did not keep the low bits.");

  chk_bresp_map: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> bvalid && (bresp == (wr_hit ? `MAU_RESP_OKAY : `MAU_RESP_SLVERR)))
    else $error("Write answer does not match the address decode.");

  chk_read_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && (araddr == `MAU_OFF_COUNT)) |=>
    rvalid && (rdata == $past(count)) && (rresp == `MAU_RESP_OKAY))
    else $error("Count read answer late or wrong.");

  // A clear run bit must freeze a registered pipeline even while enable stays high.
  chk_run_freeze: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7] [RQ14]
    (LAT_EFF > 0 && !run) |=> $stable(result))
    else $error("Result moved while the run bit was clear.");

  chk_cnt_idle: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ14]
    !adv |=> $stable(count))
    else $error("Sample counter moved without an accepted sample.");

  chk_strb_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_ctrl && !wr_strb[0]) |=> $stable(run))
    else $error("Control write without its byte strobe changed the run bit.");

  chk_wr_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid |-> (!awready && !wready))
    else $error("Write channel ready while a response is pending.");

  chk_rd_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> !arready)
    else $error("Read address ready while read data is pending.");

  chk_b_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    b_hs |=> !bvalid)
    else $error("Write response stayed after it was taken.");

  chk_r_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    r_hs |=> !rvalid)
    else $error("Read data stayed after it was taken.");

  chk_rd_slverr: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && !rd_hit) |=> rvalid && (rresp == `MAU_RESP_SLVERR) && (rdata == 32'h0000_0000))
    else $error("Unmapped read did not answer with an error and zero data.");

  cov_sub_run: cover property (@(posedge aclk) disable iff (!aresetn) adv && do_sub);
  cov_add_run: cover property (@(posedge aclk) disable iff (!aresetn) adv && !do_sub);
  cov_en_stall: cover property (@(posedge aclk) disable iff (!aresetn) adv ##1 !adv ##1 adv);
  cov_ctrl_wr: cover property (@(posedge aclk) disable iff (!aresetn) ctrl_we && !next_run);
  cov_wr_err: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && !wr_hit);

endmodule

// ===== verif/mau_feed.sv
/*
  Operand source standing in for the upstream datapath of the multiply-add unit.
  Assumes one clock; it offers a new sample after every rising edge, whether or not it is taken.
*/
`timescale 1ns/100ps
module mau_feed (
  input wire logic aclk,
  input wire logic aresetn,
  output logic signed [15:0] op_a,
  output logic signed [15:0] op_b,
  output logic signed [31:0] op_c,
  output logic subtract
);
  logic [15:0] k;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      k <= 16'h0000;
    end else begin
      k <= k + 16'h0001;
    end
  end

  // Two pairs in every four are extremes so that the widest sums and differences really occur.
  // All three operands are plain signed integers, a and b of 16 bits and c of 32, so c sits at binary point 0.
  always_ff @(posedge aclk) begin
    op_a <= (k[1:0] == 2'h0) ? 16'h8000 : (k[1:0] == 2'h1) ? 16'h7fff : 16'(k * 16'h1357);
    op_b <= (k[1] == 1'b0) ? 16'h8000 : 16'(~k ^ 16'h0bad);
    op_c <= (k[1:0] == 2'h0) ? 32'h7fff_ffff : (k[1:0] == 2'h1) ? 32'h8000_0000 : {k, ~k};
    subtract <= k[2];
  end
endmodule

// ===== verif/test_mau_top.sv
/*
  Self-checking bench of the multiply-add unit in its default build: selectable add or subtract,
  enable port, optimal three-stage pipeline; beside it a fixed-add build with user precision and a
  fixed-subtract build, both combinational without enable. Assumes mau_feed supplies the operands.
*/
`timescale 1ns/100ps
`include "mau_defs.svh"
module test_mau_top;
  logic aclk, aresetn, subtract, enable;
  logic signed [15:0] op_a, op_b;
  logic signed [31:0] op_c;
  logic [32:0] result;
  logic [19:0] result_add;
  logic [32:0] result_sub;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [`MAU_AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, cnt_exp;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [32:0] exp_q [3];
  logic run_exp;
  int failures, checked;

  mau_feed mau_feed_inst (.aclk(aclk), .aresetn(aresetn), .op_a(op_a), .op_b(op_b), .op_c(op_c),
    .subtract(subtract));
  mau_top mau_top_inst (.aclk(aclk), .aresetn(aresetn), .op_a(op_a), .op_b(op_b), .op_c(op_c),
    .subtract(subtract), .enable(enable), .result(result), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  // The extra builds reach the fixed modes, zero latency and user precision; their register ports stay idle.
  mau_top #(.OP_MODE(mau_pkg::MAU_OP_ADD), .HAS_EN(1'b0), .LATENCY(0), .FULL_PREC(1'b0), .OUT_W(20))
    mau_top_add_inst (.aclk(aclk), .aresetn(aresetn), .op_a(op_a), .op_b(op_b), .op_c(op_c),
    .subtract(subtract), .enable(1'b0), .result(result_add), .awvalid(1'b0), .awready(), .awaddr(8'h00),
    .wvalid(1'b0), .wready(), .wdata(32'h0000_0000), .wstrb(4'h0), .bvalid(), .bready(1'b0), .bresp(),
    .arvalid(1'b0), .arready(), .araddr(8'h00), .rvalid(), .rready(1'b0), .rdata(), .rresp());
  mau_top #(.OP_MODE(mau_pkg::MAU_OP_SUB), .HAS_EN(1'b0), .LATENCY(0))
    mau_top_sub_inst (.aclk(aclk), .aresetn(aresetn), .op_a(op_a), .op_b(op_b), .op_c(op_c),
    .subtract(subtract), .enable(1'b0), .result(result_sub), .awvalid(1'b0), .awready(), .awaddr(8'h00),
    .wvalid(1'b0), .wready(), .wdata(32'h0000_0000), .wstrb(4'h0), .bvalid(), .bready(1'b0), .bresp(),
    .arvalid(1'b0), .arready(), .araddr(8'h00), .rvalid(), .rready(1'b0), .rdata(), .rresp());

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [32:0] mac(input logic signed [15:0] a, input logic signed [15:0] b,
    input logic signed [31:0] c, input logic s);
    longint p;
    p = longint'(a) * longint'(b);
    return s ? 33'(p - longint'(c)) : 33'(p + longint'(c));
  endfunction

  task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    chk_val(what, {62'h0, exp}, {62'h0, got});
  endtask

  // Each access starts one edge later, so a strobe dropped by the last access is never raised in the same step.
  task automatic wr(input logic [`MAU_AXI_AW-1:0] addr, input logic [31:0] data, input logic [1:0] er,
    input string what);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= addr;
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    chk_resp(what, er, bvalid ? bresp : 2'bxx);
  endtask

  task automatic rd(input logic [`MAU_AXI_AW-1:0] addr, input logic [31:0] ed, input logic [1:0] er,
    input string what);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    chk_resp(what, er, rvalid ? rresp : 2'bxx);
    chk_val(what, {32'h0, ed}, {32'h0, rdata});
  endtask

  // Enable drops one cycle in five so that stalls land between back-to-back samples.
  task automatic stream(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      enable <= (i % 5 != 3);
    end
    @(posedge aclk);
    enable <= 1'b0;
    // One more edge lets the last accepted sample settle in the model before anyone reads it.
    @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    if (!aresetn) begin
      exp_q <= '{default: 33'h0};
      cnt_exp <= 32'h0;
    end else if (enable && run_exp) begin
      exp_q[0] <= mac(op_a, op_b, op_c, subtract);
      exp_q[1] <= exp_q[0];
      exp_q[2] <= exp_q[1];
      cnt_exp <= cnt_exp + 32'h1;
    end
  end

  always @(negedge aclk) begin
    if (aresetn) begin
      chk_val("result", {31'h0, exp_q[2]}, {31'h0, result});
      chk_val("result add", {44'h0, 20'(mac(op_a, op_b, op_c, 1'b0))}, {44'h0, result_add});
      chk_val("result sub", {31'h0, mac(op_a, op_b, op_c, 1'b1)}, {31'h0, result_sub});
    end
  end

  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    stop_test;
  end

  initial begin
    aresetn = 1'b0;
    enable = 1'b0;
    run_exp = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MAU_OFF_CTRL, `MAU_CTRL_RST, `MAU_RESP_OKAY, "ctrl reset");
    rd(`MAU_OFF_COUNT, `MAU_COUNT_RST, `MAU_RESP_OKAY, "count reset");
    wr(`MAU_OFF_COUNT, 32'h0000_0055, `MAU_RESP_OKAY, "count write");
    rd(`MAU_OFF_COUNT, 32'h0000_0000, `MAU_RESP_OKAY, "count read only");
    rd(8'h10, 32'h0000_0000, `MAU_RESP_SLVERR, "unmapped read");
    wr(8'h14, 32'hffff_ffff, `MAU_RESP_SLVERR, "unmapped write");
    wstrb <= 4'h0;
    wr(`MAU_OFF_CTRL, 32'h0000_0000, `MAU_RESP_OKAY, "ctrl no strobe");
    wstrb <= 4'hf;
    rd(`MAU_OFF_CTRL, `MAU_CTRL_RST, `MAU_RESP_OKAY, "ctrl kept");
    $display("test registers done");
    stream(60);
    rd(`MAU_OFF_COUNT, cnt_exp, `MAU_RESP_OKAY, "count stream");
    rd(`MAU_OFF_RES_LO, exp_q[2][31:0], `MAU_RESP_OKAY, "result low");
    rd(`MAU_OFF_RES_HI, {32{exp_q[2][32]}}, `MAU_RESP_OKAY, "result high");
    $display("test stream done");
    wr(`MAU_OFF_CTRL, 32'h0000_0000, `MAU_RESP_OKAY, "run off");
    run_exp <= 1'b0;
    stream(10);
    rd(`MAU_OFF_COUNT, cnt_exp, `MAU_RESP_OKAY, "count frozen");
    wr(`MAU_OFF_CTRL, 32'h0000_0001, `MAU_RESP_OKAY, "run on");
    run_exp <= 1'b1;
    stream(20);
    rd(`MAU_OFF_COUNT, cnt_exp, `MAU_RESP_OKAY, "count resumed");
    $display("test freeze done");
    // A second reset in mid-run must clear the pipeline and the sample count alike.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MAU_OFF_COUNT, 32'h0000_0000, `MAU_RESP_OKAY, "count rereset");
    stream(12);
    $display("test rereset done");
    stop_test;
  end
endmodule
